// ### pkg/cpu_pc_flags_map.svh
`ifndef CPU_PC_FLAGS_MAP_SVH
`define CPU_PC_FLAGS_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFF_FLAGS   8'h00
`define OFF_IP      8'h04
`define OFF_STAT    8'h08
// ----------------------------------------
// vectors and reset values
// ----------------------------------------
`define VEC_HI_ADDR 16'hfffe
`define VEC_LO_ADDR 16'hffff
`define IP_RESET    16'h0000
`define FLAGS_RESET 8'h68
`define ONE16       16'h0001
`define ZERO16      16'h0000
`define ZERO8       8'h00
// ----------------------------------------
// flag bit positions and masks
// ----------------------------------------
`define FLG_V       7
`define FLG_H       4
`define FLG_I       3
`define FLG_N       2
`define FLG_Z       1
`define FLG_C       0
`define FLG_ONES    8'h60
`define FLG_WMASK   8'h9f
// ----------------------------------------
// decimal adjust constants
// ----------------------------------------
`define DAA_LO_ADD  8'h06
`define DAA_HI_ADD  8'h60
`define BCD_NIB_MAX 4'h9
`define BCD_MAX     8'h99
`endif

// ### pkg/cpu_pc_flags_pkg.sv
package cpu_pc_flags_pkg;
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_VEC_HI = 3'b001,
    S_VEC_LO = 3'b010,
    S_RD_A   = 3'b011,
    S_RD_B   = 3'b100
  } state_t;
  typedef enum logic [2:0] {
    OP_INH    = 3'b000,
    OP_FETCH  = 3'b001,
    OP_LIT16  = 3'b010,
    OP_BRANCH = 3'b011,
    OP_JUMP   = 3'b100
  } op_t;
  typedef enum logic [3:0] {
    K_ADD        = 4'b0000,
    K_ADC        = 4'b0001,
    K_SUB        = 4'b0010,
    K_SBC        = 4'b0011,
    K_LOGIC      = 4'b0100,
    K_LOAD8      = 4'b0101,
    K_LOAD16     = 4'b0110,
    K_DAA        = 4'b0111,
    K_MASK_CLR   = 4'b1000,
    K_FLAGS_LOAD = 4'b1001
  } alu_kind_t;
endpackage

// ### src/cpu_pc_flags.sv
// Operation
// RQ1: keep a 16-bit pointer to the next instruction or operand byte.
// RQ2: advance the pointer by one on every byte fetched.
// RQ3: jump, branch, interrupt and return load a non-sequential target.
// RQ4: after reset load the pointer from 0xfffe (high) and 0xffff (low).
// RQ5: flag bits 6 and 5 always read one; writes to them are ignored.
// RQ6: bit 7 flags two's complement overflow, cleared otherwise.
// RQ7: bit 4 flags a carry from bit 3 into bit 4 on add.
// RQ8: decimal adjust corrects a prior add using nibble-carry and carry.
// RQ9: interrupt mask bit 3 set blocks maskable interrupts; clear allows them.
// RQ10: mask is set after registers are stacked, before the handler runs.
// RQ11: no interrupt at the boundary right after an instruction clears the mask.
// RQ12: bit 2 follows the top bit of results, loads and stores.
// RQ13: bit 1 set when the result or moved value is zero.
// RQ14: bit 0 is add carry out of bit 7 or subtract borrow.
// RQ15: every access uses one shared 64-Kbyte space with a 16-bit address.
// RQ16: test-and-branch uses the tested result, then a relative branch target.
// RQ17: register-only mode makes no memory access for operands.
// RQ18: branch reads a signed offset after the opcode, adds it if taken.
// RQ19: literals follow the opcode; a 16-bit literal is high byte first.
// RQ20: an untaken branch continues after the offset, flags unchanged.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`include "cpu_pc_flags_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cpu_pc_flags (
  // clock, reset, enable
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // sequencer command port
  input  wire logic                        op_valid,
  input  wire cpu_pc_flags_pkg::op_t       op_code,
  input  wire logic                        br_cond,
  input  wire logic [15:0]                 jump_target,
  output logic                             op_ready,
  output logic                             done,
  output logic      [15:0]                 fetch_data,
  // flag update port
  input  wire logic                        alu_valid,
  input  wire cpu_pc_flags_pkg::alu_kind_t alu_kind,
  input  wire logic [7:0]                  alu_a,
  input  wire logic [7:0]                  alu_b,
  input  wire logic [15:0]                 alu_res16,
  output logic      [7:0]                  alu_result,
  // memory space
  output logic                             mem_rd,
  output logic      [15:0]                 mem_addr,
  input  wire logic                        mem_ready,
  input  wire logic [7:0]                  mem_rdata,
  // interrupt gating
  input  wire logic                        irq_req,
  input  wire logic                        insn_boundary,
  input  wire logic                        stack_saved,
  output logic                             irq_take,
  // state view
  output logic      [7:0]                  flags_out,
  output logic      [15:0]                 ip_out
);
  import cpu_pc_flags_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // negative and zero pair for an 8-bit value
  function automatic logic [1:0] nz8(input logic [7:0] v);
    nz8 = {v[7], v == `ZERO8};
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFF_FLAGS) || (a == `OFF_IP) || (a == `OFF_STAT);
  endfunction

  state_t      state_reg;
  op_t         op_reg;
  logic        cond_reg;
  logic [7:0]  byte_reg;
  logic [15:0] ip_reg;
  logic [15:0] ip_next;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [7:0]  alu_f;
  logic [7:0]  alu_r;
  logic        inhibit_reg;
  logic        done_reg;
  logic [15:0] data_reg;
  logic [7:0]  res_reg;
  logic [31:0] prdata_reg;
  logic        take;
  logic        apb_wr;
  logic        clears_i;

  // ----------------------------------------
  // fetch sequencer
  // ----------------------------------------
  // memory strobe held until the memory answers; address in one 64-Kbyte space
  always_comb begin
    mem_rd   = 1'b0;
    mem_addr = ip_reg;
    unique case (state_reg)
      S_IDLE:   mem_rd = 1'b0;                                  // see RQ17
      S_VEC_HI: begin
        mem_rd   = 1'b1;
        mem_addr = `VEC_HI_ADDR;                                // see RQ4
      end
      S_VEC_LO: begin
        mem_rd   = 1'b1;
        mem_addr = `VEC_LO_ADDR;
      end
      S_RD_A, S_RD_B: begin
        mem_rd   = 1'b1;
        mem_addr = ip_reg;                                      // see RQ15
      end
    endcase
  end

  // reset starts in the vector fetch, so no command is taken until it ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_VEC_HI;
      op_reg    <= OP_INH;
      cond_reg  <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        S_IDLE: if (op_valid) begin
          op_reg   <= op_code;
          cond_reg <= br_cond;                                  // see RQ16
          if (op_code == OP_FETCH || op_code == OP_LIT16 || op_code == OP_BRANCH) begin
            state_reg <= S_RD_A;
          end
        end
        S_VEC_HI: if (mem_ready) begin
          state_reg <= S_VEC_LO;
        end
        S_VEC_LO: if (mem_ready) begin
          state_reg <= S_IDLE;
        end
        S_RD_A: if (mem_ready) begin
          state_reg <= (op_reg == OP_LIT16) ? S_RD_B : S_IDLE;  // see RQ19
        end
        S_RD_B: if (mem_ready) begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // instruction pointer
  // ----------------------------------------
  always_comb begin
    ip_next = ip_reg;
    unique case (state_reg)
      S_IDLE: if (op_valid && op_code == OP_JUMP) begin
        ip_next = jump_target;                                  // see RQ3
      end
      S_VEC_HI: ip_next = ip_reg;
      S_VEC_LO: if (mem_ready) begin
        ip_next = {byte_reg, mem_rdata};                        // see RQ4
      end
      S_RD_A: if (mem_ready) begin
        // taken branch is relative to the byte after the offset
        if (op_reg == OP_BRANCH && cond_reg) begin
          ip_next = ip_reg + `ONE16 + sext8(mem_rdata);         // see RQ18
        end else begin
          ip_next = ip_reg + `ONE16;                            // see RQ2, see RQ20
        end
      end
      S_RD_B: if (mem_ready) begin
        ip_next = ip_reg + `ONE16;                              // see RQ2
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ip_reg <= `IP_RESET;                                      // see RQ1
    end else if (ce) begin
      ip_reg <= ip_next;
    end
  end

  // first byte of a vector or 16-bit literal waits here for its partner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_reg <= `ZERO8;
    end else if (ce && mem_ready && (state_reg == S_VEC_HI || state_reg == S_RD_A)) begin
      byte_reg <= mem_rdata;
    end
  end

  // completion pulse with the fetched byte or literal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      data_reg <= `ZERO16;
    end else if (ce) begin
      done_reg <= 1'b0;
      if (state_reg == S_IDLE && op_valid &&
          (op_code == OP_INH || op_code == OP_JUMP)) begin
        done_reg <= 1'b1;
      end
      if (state_reg == S_VEC_LO && mem_ready) begin
        done_reg <= 1'b1;
      end
      if (state_reg == S_RD_A && mem_ready && op_reg != OP_LIT16) begin
        done_reg <= 1'b1;
        data_reg <= {`ZERO8, mem_rdata};
      end
      if (state_reg == S_RD_B && mem_ready) begin
        done_reg <= 1'b1;
        data_reg <= {byte_reg, mem_rdata};                      // see RQ19
      end
    end
  end

  // ----------------------------------------
  // flag computation
  // ----------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic       fix_lo;
    logic       fix_hi;
    sum    = 9'h000;
    fix_lo = 1'b0;
    fix_hi = 1'b0;
    alu_f  = flags_reg;
    alu_r  = res_reg;
    unique case (alu_kind)
      K_ADD, K_ADC: begin
        sum   = add9(alu_a, alu_b, (alu_kind == K_ADC) && flags_reg[`FLG_C]);
        alu_r = sum[7:0];
        alu_f[`FLG_V] = (alu_a[7] == alu_b[7]) && (alu_r[7] != alu_a[7]); // see RQ6
        alu_f[`FLG_H] = alu_a[4] ^ alu_b[4] ^ alu_r[4];                 // see RQ7
        alu_f[`FLG_C] = sum[8];                                         // see RQ14
        {alu_f[`FLG_N], alu_f[`FLG_Z]} = nz8(alu_r);
      end
      K_SUB, K_SBC: begin
        sum   = add9(alu_a, ~alu_b, (alu_kind == K_SUB) || !flags_reg[`FLG_C]);
        alu_r = sum[7:0];
        alu_f[`FLG_V] = (alu_a[7] != alu_b[7]) && (alu_r[7] != alu_a[7]); // see RQ6
        alu_f[`FLG_C] = !sum[8];                                        // see RQ14
        {alu_f[`FLG_N], alu_f[`FLG_Z]} = nz8(alu_r);
      end
      K_LOGIC, K_LOAD8: begin
        alu_r = alu_a;
        alu_f[`FLG_V] = 1'b0;
        {alu_f[`FLG_N], alu_f[`FLG_Z]} = nz8(alu_r);                    // see RQ12, see RQ13
      end
      K_LOAD16: begin
        alu_r = alu_res16[7:0];
        alu_f[`FLG_V] = 1'b0;
        alu_f[`FLG_N] = alu_res16[15];                                  // see RQ12
        alu_f[`FLG_Z] = (alu_res16 == `ZERO16);                         // see RQ13
      end
      K_DAA: begin
        // correction depends on the flags the previous add left behind and on the value in alu_a
        fix_lo = flags_reg[`FLG_H] || (alu_a[3:0] > `BCD_NIB_MAX);
        fix_hi = flags_reg[`FLG_C] || (alu_a > `BCD_MAX);
        alu_r  = alu_a + (fix_hi ? `DAA_HI_ADD : `ZERO8) + (fix_lo ? `DAA_LO_ADD : `ZERO8);
        alu_f[`FLG_C] = fix_hi;                                         // see RQ8
        {alu_f[`FLG_N], alu_f[`FLG_Z]} = nz8(alu_r);
      end
      K_MASK_CLR:   alu_f[`FLG_I] = 1'b0;                               // see RQ9
      K_FLAGS_LOAD: alu_f = alu_a;
      default:      alu_f = flags_reg;
    endcase
  end

  // apb write first, then the flag port, then stacking sets the mask last
  assign apb_wr = psel && penable && pwrite && (paddr == `OFF_FLAGS);
  always_comb begin
    flags_next = flags_reg;
    if (apb_wr) begin
      flags_next = pwdata[7:0] & `FLG_WMASK;
    end
    if (alu_valid) begin
      flags_next = alu_f;
    end
    if (stack_saved) begin
      flags_next[`FLG_I] = 1'b1;                                // see RQ10
    end
    flags_next = flags_next | `FLG_ONES;                        // see RQ5
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= `FLAGS_RESET;
      res_reg   <= `ZERO8;
    end else if (ce) begin
      flags_reg <= flags_next;
      if (alu_valid) begin
        res_reg <= alu_r;
      end
    end
  end

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  // an instruction that drops the mask hides the next boundary; set beats clear
  assign clears_i = flags_reg[`FLG_I] && !flags_next[`FLG_I];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_reg <= 1'b0;
    end else if (ce) begin
      if (clears_i) begin
        inhibit_reg <= 1'b1;                                    // see RQ11
      end else if (insn_boundary) begin
        inhibit_reg <= 1'b0;
      end
    end
  end

  assign take = ce && insn_boundary && irq_req && !flags_reg[`FLG_I] && !inhibit_reg; // see RQ9

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // read data latched in the setup cycle so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFF_FLAGS: prdata_reg <= {24'h00_0000, flags_reg};
        `OFF_IP:    prdata_reg <= {16'h0000, ip_reg};
        `OFF_STAT:  prdata_reg <= {29'h0000_0000, inhibit_reg, flags_reg[`FLG_I],
                                   state_reg != S_IDLE};
        default:    prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped(paddr);
  assign op_ready   = (state_reg == S_IDLE);
  assign done       = done_reg;
  assign fetch_data = data_reg;
  assign alu_result = res_reg;
  assign irq_take   = take;
  assign flags_out  = flags_reg;
  assign ip_out     = ip_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fixed_ones: assert property (flags_reg[6:5] == 2'b11)               // see RQ5
    else $error("fixed flag bits not one");
  a_seq_incr: assert property (ce && mem_ready && state_reg == S_RD_B   // see RQ2
    |=> ip_reg == $past(ip_reg) + `ONE16)
    else $error("pointer did not advance by one");
  a_vector_load: assert property (ce && mem_ready && state_reg == S_VEC_LO // see RQ4
    |=> ip_reg == {$past(byte_reg), $past(mem_rdata)} && op_ready)
    else $error("reset vector not loaded");
  a_jump_load: assert property (ce && op_ready && op_valid && op_code == OP_JUMP // see RQ3
    |=> ip_reg == $past(jump_target) ##0 done)
    else $error("jump target not loaded");
  a_branch_taken: assert property (ce && mem_ready && state_reg == S_RD_A // see RQ18
    && op_reg == OP_BRANCH && cond_reg
    |=> ip_reg == $past(ip_reg) + `ONE16 + sext8($past(mem_rdata)))
    else $error("taken branch target wrong");
  a_branch_skip: assert property (ce && mem_ready && state_reg == S_RD_A // see RQ20
    && op_reg == OP_BRANCH && !cond_reg && !alu_valid && !apb_wr && !stack_saved
    |=> ip_reg == $past(ip_reg) + `ONE16 && $stable(flags_reg))
    else $error("untaken branch wrong");
  a_inh_nomem: assert property (ce && op_ready && op_valid && op_code == OP_INH // see RQ17
    |=> !mem_rd [*2])
    else $error("register-only op touched memory");
  a_mask_block: assert property (irq_take |-> !flags_reg[`FLG_I] && !inhibit_reg) // see RQ9
    else $error("interrupt taken while masked");
  a_mask_set: assert property (ce && stack_saved |=> flags_reg[`FLG_I]) // see RQ10
    else $error("mask not set after stacking");
  a_clear_hides: assert property (ce && alu_valid && alu_kind == K_MASK_CLR // see RQ11
    && flags_reg[`FLG_I] |=> !irq_take && (inhibit_reg || flags_reg[`FLG_I]))
    else $error("interrupt at boundary after mask clear");
  a_half_carry: assert property (ce && alu_valid && alu_kind == K_ADD && !stack_saved // see RQ7
    |=> flags_reg[`FLG_H] == ({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])} > 5'h0f))
    else $error("half carry wrong");
  a_load_nz: assert property (ce && alu_valid && alu_kind == K_LOAD8     // see RQ13
    |=> flags_reg[`FLG_Z] == ($past(alu_a) == `ZERO8) && flags_reg[`FLG_N] == $past(alu_a[7]))
    else $error("zero or negative flag wrong");

  c_vector:  cover property (state_reg == S_VEC_LO && mem_ready ##1 op_ready);
  c_taken:   cover property (state_reg == S_RD_A && op_reg == OP_BRANCH && cond_reg && mem_ready);
  c_lit16:   cover property (state_reg == S_RD_B && mem_ready ##1 done);
  c_irq:     cover property (irq_take);
endmodule
`default_nettype wire

// ### verif/mem_space_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// memory and peripheral space model
// ----------------------------------------
module mem_space_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // read port
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  wait_cyc,
  output logic             mem_ready,
  output logic [7:0]       mem_rdata
);
  logic [1:0] cnt_reg;
  logic [7:0] last_reg;
  // answers after wait_cyc idle cycles, so both prompt and slow replies occur
  assign mem_ready = mem_rd && (cnt_reg == wait_cyc);
  // byte follows its address, so no 64k array; off a read the lines show ~last
  assign mem_rdata = mem_ready ? (mem_addr[7:0] + mem_addr[15:8] + 8'h11) : ~last_reg;
  // wait counter restarts after every completed read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 2'h0;
      last_reg <= 8'h00;
    end else if (mem_ready) begin
      cnt_reg  <= 2'h0;
      last_reg <= mem_rdata;
    end else if (mem_rd) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cpu_pc_flags_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        op_valid, br_cond, op_ready, done, alu_valid, mem_rd, mem_ready;
  logic        irq_req, insn_boundary, stack_saved, irq_take, err, seen_rd;
  logic [1:0]  wait_cyc;
  logic [7:0]  paddr, alu_a, alu_b, alu_result, mem_rdata, flags_out, f0;
  logic [15:0] jump_target, alu_res16, fetch_data, mem_addr, ip_out, ip, seen_addr;
  logic [31:0] pwdata, prdata, rd;
  op_t         op_code;
  alu_kind_t   alu_kind;
  int          error_cnt, samples_checked;
  typedef struct packed {
    alu_kind_t  k;
    logic [7:0] a, b, r, rm, fm, f;
  } alu_case_t;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  cpu_pc_flags uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .br_cond(br_cond),
    .jump_target(jump_target), .op_ready(op_ready), .done(done), .fetch_data(fetch_data),
    .alu_valid(alu_valid), .alu_kind(alu_kind), .alu_a(alu_a), .alu_b(alu_b),
    .alu_res16(alu_res16), .alu_result(alu_result), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .irq_req(irq_req),
    .insn_boundary(insn_boundary), .stack_saved(stack_saved), .irq_take(irq_take),
    .flags_out(flags_out), .ip_out(ip_out)
  );
  mem_space_model mem (
    .pclk(pclk), .presetn(presetn), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .wait_cyc(wait_cyc), .mem_ready(mem_ready), .mem_rdata(mem_rdata)
  );
  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h11;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // apb master: request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(1, 0);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // command port: hold until taken, then watch memory traffic until done
  task automatic run_op(input op_t op, input logic cond, input logic [15:0] tgt);
    int n;
    @(posedge pclk);
    op_valid    <= 1'b1;
    op_code     <= op;
    br_cond     <= cond;
    jump_target <= tgt;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (op_ready !== 1'b1 && n < 50);
    @(posedge pclk);
    op_valid <= 1'b0;
    seen_rd = 1'b0;
    n = 0;
    do begin
      @(negedge pclk);
      if (mem_rd === 1'b1 && !seen_rd) begin
        seen_rd   = 1'b1;
        seen_addr = mem_addr;
      end
      n++;
    end while (done !== 1'b1 && n < 50);
    if (n >= 50) chk(1, 0);
  endtask
  task automatic alu(input alu_kind_t k, input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    alu_valid <= 1'b1;
    alu_kind  <= k;
    alu_a     <= a;
    alu_b     <= b;
    alu_res16 <= {a, b};
    @(posedge pclk);
    alu_valid <= 1'b0;
    @(negedge pclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (op_ready !== 1'b1 && n < 50);
    chk(ip_out, 16'h0e0f);
    chk(flags_out, 8'h68);
    $display("reset vector test done");
  endtask
  // prompt and slow memory, back to back fetches
  task automatic t_fetch();
    for (int w = 0; w < 3; w += 2) begin
      wait_cyc <= 2'(w);
      ip = ip_out;
      run_op(OP_FETCH, 1'b0, 16'h0000);
      chk(seen_addr, ip);
      chk(fetch_data[7:0], mb(ip));
      chk(ip_out, ip + 16'h0001);
    end
    ip = ip_out;
    run_op(OP_LIT16, 1'b0, 16'h0000);
    chk(fetch_data, {mb(ip), mb(ip + 16'h0001)});
    chk(ip_out, ip + 16'h0002);
    $display("fetch test done");
  endtask
  task automatic t_flow();
    run_op(OP_JUMP, 1'b0, 16'h4040);
    chk(ip_out, 16'h4040);
    run_op(OP_INH, 1'b0, 16'h1234);
    chk(seen_rd, 1'b0);
    chk(ip_out, 16'h4040);
    f0 = mb(16'h4040);
    run_op(OP_BRANCH, 1'b1, 16'h0000);
    chk(ip_out, 16'(16'h4041 + {{8{f0[7]}}, f0}));
    ip = ip_out;
    f0 = flags_out;
    run_op(OP_BRANCH, 1'b0, 16'h0000);
    chk(ip_out, ip + 16'h0001);
    chk(flags_out, f0);
    $display("change of flow test done");
  endtask
  task automatic t_regs();
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0060);
    apb(1'b1, 8'h00, 32'h0000_00ff);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, {16'h0000, ip_out});
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0008);
    $display("register test done");
  endtask
  // every flag update kind except K_MASK_CLR, flags start at 0x68
  task automatic t_alu();
    alu_case_t tbl [14] = '{
      '{K_ADD, 8'h7f, 8'h01, 8'h80, 8'hff, 8'hff, 8'hfc},
      '{K_ADD, 8'hff, 8'h01, 8'h00, 8'hff, 8'hff, 8'h7b},
      '{K_ADC, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff, 8'h68},
      '{K_SUB, 8'h00, 8'h01, 8'hff, 8'hff, 8'h87, 8'h05},
      '{K_SBC, 8'h80, 8'h00, 8'h7f, 8'hff, 8'h87, 8'h80},
      '{K_LOGIC, 8'h80, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00},
      '{K_SUB, 8'h80, 8'h01, 8'h7f, 8'hff, 8'h87, 8'h80},
      '{K_LOAD8, 8'h80, 8'h00, 8'h80, 8'hff, 8'h86, 8'h04},
      '{K_LOAD16, 8'h00, 8'h00, 8'h00, 8'h00, 8'h86, 8'h02},
      '{K_ADD, 8'h19, 8'h28, 8'h41, 8'hff, 8'hff, 8'h78},
      '{K_DAA, 8'h41, 8'h00, 8'h47, 8'hff, 8'h07, 8'h00},
      '{K_ADD, 8'h99, 8'h01, 8'h9a, 8'hff, 8'hff, 8'h6c},
      '{K_DAA, 8'h9a, 8'h00, 8'h00, 8'hff, 8'h07, 8'h03},
      '{K_FLAGS_LOAD, 8'h08, 8'h00, 8'h00, 8'h00, 8'hff, 8'h68}
    };
    foreach (tbl[i]) begin
      alu(tbl[i].k, tbl[i].a, tbl[i].b);
      chk(flags_out & tbl[i].fm, tbl[i].f);
      chk(alu_result & tbl[i].rm, tbl[i].r & tbl[i].rm);
    end
    // clock enable low freezes the flags even with an update strobe
    @(posedge pclk);
    ce <= 1'b0;
    alu(K_ADD, 8'hff, 8'h01);
    chk(flags_out, 8'h68);
    @(posedge pclk);
    ce <= 1'b1;
    $display("flag update test done");
  endtask
  task automatic t_irq();
    @(posedge pclk);
    irq_req       <= 1'b1;
    insn_boundary <= 1'b1;
    @(negedge pclk);
    chk(irq_take, 1'b0);
    @(posedge pclk);
    insn_boundary <= 1'b0;
    alu(K_MASK_CLR, 8'h00, 8'h00);
    @(posedge pclk);
    insn_boundary <= 1'b1;
    @(negedge pclk);
    chk(irq_take, 1'b0);
    @(negedge pclk);
    chk(irq_take, 1'b1);
    @(posedge pclk);
    insn_boundary <= 1'b0;
    stack_saved   <= 1'b1;
    @(posedge pclk);
    stack_saved   <= 1'b0;
    insn_boundary <= 1'b1;
    @(negedge pclk);
    chk(flags_out[3], 1'b1);
    chk(irq_take, 1'b0);
    $display("interrupt mask test done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, op_valid, br_cond, alu_valid, presetn} = '0;
    {irq_req, insn_boundary, stack_saved, wait_cyc} = '0;
    {paddr, pwdata, jump_target, alu_a, alu_b, alu_res16} = '0;
    ce = 1'b1;
    op_code = OP_INH;
    alu_kind = K_ADD;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fetch();
    t_flow();
    t_regs();
    t_alu();
    t_irq();
    conclude();
  end
  // watchdog, far beyond the hundred or so cycles the scenarios need
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
